// ===== rtl/dma_flow_pkg.sv
package dma_flow_pkg;
    // Channel count of the controller
    localparam int NUM_CHANNELS    = 12;
    // Only channel that external hardware may start
    localparam int HW_START_CHAN   = 4;
    // Reset value of the per-channel start mask
    localparam logic [11:0] HW_START_MASK_RST = 12'h010;
    // Synchroniser depth for inputs from another clock domain
    localparam int SYNC_STAGES     = 3;
    // Transfer size encodings
    localparam logic [1:0] SIZE_BYTE  = 2'h0;
    localparam logic [1:0] SIZE_HALF  = 2'h1;
    localparam logic [1:0] SIZE_WORD  = 2'h2;
endpackage

// ===== rtl/dma_sync_bit.sv
`timescale 1ns/1ps
module dma_sync_bit (
    input  wire logic sys_clk,  // DMA clock
    input  wire logic rstn,     // Synchronous reset, active low
    input  wire logic async_in, // Level from another domain
    output logic      level_q,  // Filtered level, registered
    output logic      rise      // One-cycle pulse on accepted rise
);
    logic [2:0] stage_q;

    // Three flops; change counts once second and third agree
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            stage_q <= 3'h0;
            level_q <= 1'b0;
        end else begin
            stage_q <= {stage_q[1:0], async_in};
            if (stage_q[1] == stage_q[2]) begin
                level_q <= stage_q[2];
            end
        end
    end

    assign rise = (stage_q[1] == stage_q[2]) && stage_q[2] && !level_q;
endmodule // dma_sync_bit

// ===== rtl/dma_flow_control_handshake.sv
`timescale 1ns/1ps
module dma_flow_control_handshake
    import dma_flow_pkg::*;
#(
    parameter int          NCH        = NUM_CHANNELS,
    parameter logic [11:0] START_MASK = HW_START_MASK_RST
) (
    input  wire logic           sys_clk,              // DMA clock
    input  wire logic           rstn,                 // Sync reset, low
    input  wire logic           single_xfer_request,  // Slave single req
    input  wire logic           final_xfer_request,   // Slave last req
    input  wire logic           xfer_complete,        // Mover finished item
    output logic                xfer_request,         // Ask mover for item
    output logic                xfer_is_last,         // Item is final one
    output logic                terminal_count_out,   // Last item pulse
    output logic                xfer_done_strobe,     // Item done pulse
    input  wire logic [NCH-1:0] hw_channel_start,     // External start
    input  wire logic [NCH-1:0] channel_finished,     // Channel end pulses
    output logic      [NCH-1:0] channel_start,        // Start pulses
    output logic      [NCH-1:0] hw_channel_start_ack  // Finish ack
);
    typedef enum logic [1:0] {IDLE, BUSY, DONE} flow_state_type;
    flow_state_type state_q, state_d;
    logic           last_q;
    logic [NCH-1:0] start_level;
    logic [NCH-1:0] start_rise;
    logic [NCH-1:0] hw_owned_q;

    // Request seen: the final request takes precedence over single
    wire any_req  = single_xfer_request || final_xfer_request;
    wire take_req = (state_q == IDLE) && any_req;
    wire finish   = (state_q == BUSY) && xfer_complete;

    // Flow state: one request yields one item, then one strobe
    always_comb begin
        state_d = state_q;
        case (state_q)
            IDLE:    if (any_req) state_d = BUSY;
            BUSY:    if (xfer_complete) state_d = DONE;
            // relied on: slave drops request after strobe
            DONE:    state_d = IDLE;
            default: state_d = IDLE;
        endcase
    end

    assign xfer_request = (state_q == BUSY);
    assign xfer_is_last = last_q;

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            state_q            <= IDLE;
            last_q             <= 1'b0;
            xfer_done_strobe   <= 1'b0;
            terminal_count_out <= 1'b0;
        end else begin
            state_q <= state_d;
            if (take_req) begin
                last_q <= final_xfer_request;
            end
            xfer_done_strobe   <= finish;
            terminal_count_out <= finish && last_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_chan
            dma_sync_bit u_sync (
                .sys_clk  (sys_clk),
                .rstn     (rstn),
                .async_in (hw_channel_start[g]),
                .level_q  (start_level[g]),
                .rise     (start_rise[g])
            );
        end
    endgenerate

    assign channel_start = start_rise & START_MASK[NCH-1:0];

    // ack on finish of hardware-started channel
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            hw_owned_q           <= '0;
            hw_channel_start_ack <= '0;
        end else begin
            // Start wins over finish in the same cycle
            hw_owned_q <= (hw_owned_q & ~channel_finished) | channel_start;
            // Ack held until the enable is withdrawn; no crossing here
            hw_channel_start_ack <= (hw_channel_start_ack & start_level)
                | (hw_owned_q & channel_finished);
        end
    end

    a_done_after_complete: assert property (@(posedge sys_clk)
        disable iff (!rstn) finish |=> xfer_done_strobe)
        else $error("done strobe missing after completion");
    a_done_single_pulse: assert property (@(posedge sys_clk)
        disable iff (!rstn) xfer_done_strobe |=> !xfer_done_strobe)
        else $error("done strobe longer than one cycle");
    // terminal count only with done strobe
    a_tc_with_done: assert property (@(posedge sys_clk)
        disable iff (!rstn) terminal_count_out |-> xfer_done_strobe)
        else $error("terminal count without done strobe");
    a_start_masked: assert property (@(posedge sys_clk)
        disable iff (!rstn) (channel_start & ~START_MASK[NCH-1:0]) == '0)
        else $error("start on channel without hardware start");
    // ack follows finish of owned channel
    a_ack_on_finish: assert property (@(posedge sys_clk)
        disable iff (!rstn) (hw_owned_q[HW_START_CHAN]
        && channel_finished[HW_START_CHAN])
        |=> hw_channel_start_ack[HW_START_CHAN])
        else $error("ack missing after channel finish");
    // start pulse needs a settled high input
    a_start_synced: assert property (@(posedge sys_clk)
        disable iff (!rstn) channel_start[HW_START_CHAN]
        |-> $past(hw_channel_start[HW_START_CHAN], 2))
        else $error("start acted on unsynchronised input");
    a_reset_clears: assert property (@(posedge sys_clk)
        !rstn |=> !xfer_done_strobe && !terminal_count_out
        && hw_channel_start_ack == '0)
        else $error("reset did not clear outputs");
    // rising start gives one start pulse
    a_start_pulse: assert property (@(posedge sys_clk)
        disable iff (!rstn) channel_start[HW_START_CHAN]
        |=> !channel_start[HW_START_CHAN])
        else $error("start pulse longer than one cycle");

    // Flow handshake: each taken request reaches the mover exactly once,
    // and the strobe only ever follows a cycle in which an item was owed

    a_take_to_mover: assert property (@(posedge sys_clk)
        disable iff (!rstn) take_req |=> xfer_request)
        else $error("taken request not passed to mover");

    // final request marks the item as last
    a_last_latched: assert property (@(posedge sys_clk)
        disable iff (!rstn) (take_req && final_xfer_request)
        |=> xfer_is_last)
        else $error("final request not marked as last");

    // single request leaves the item not last
    a_single_not_last: assert property (@(posedge sys_clk)
        disable iff (!rstn) (take_req && !final_xfer_request)
        |=> !xfer_is_last)
        else $error("single request marked as last");

    // pending item stays pending until the mover ends it
    a_busy_holds: assert property (@(posedge sys_clk)
        disable iff (!rstn) (xfer_request && !xfer_complete)
        |=> xfer_request)
        else $error("pending item dropped before completion");

    // completion ends the request to the mover
    a_request_drops: assert property (@(posedge sys_clk)
        disable iff (!rstn) finish |=> !xfer_request)
        else $error("request to mover stayed after completion");

    // strobe only after a pending item
    a_strobe_after_busy: assert property (@(posedge sys_clk)
        disable iff (!rstn) xfer_done_strobe |-> $past(xfer_request))
        else $error("done strobe without a pending item");

    // terminal count only for the last item
    a_tc_only_last: assert property (@(posedge sys_clk)
        disable iff (!rstn) terminal_count_out |-> $past(xfer_is_last))
        else $error("terminal count on an item that was not last");

    // the cycle after the strobe is idle, ready for a new request
    a_strobe_to_idle: assert property (@(posedge sys_clk)
        disable iff (!rstn) xfer_done_strobe |=> !xfer_request)
        else $error("mover request right after done strobe");

    // Hardware start: ownership and acknowledge on the started channel

    // a start pulse makes the channel hardware owned
    a_owned_after_start: assert property (@(posedge sys_clk)
        disable iff (!rstn) channel_start[HW_START_CHAN]
        |=> hw_owned_q[HW_START_CHAN])
        else $error("started channel not marked as owned");

    // settled level needs the input high three cycles earlier
    a_sync_latency: assert property (@(posedge sys_clk)
        disable iff (!rstn) $rose(start_level[HW_START_CHAN])
        |-> $past(hw_channel_start[HW_START_CHAN], 3))
        else $error("start level rose without settled input");

    // ack only rises after an owned channel finishes
    a_ack_needs_finish: assert property (@(posedge sys_clk)
        disable iff (!rstn) $rose(hw_channel_start_ack[HW_START_CHAN])
        |-> $past(hw_owned_q[HW_START_CHAN]
        && channel_finished[HW_START_CHAN]))
        else $error("ack rose without a finished owned channel");

    // ack stands while the start level stays high
    a_ack_held: assert property (@(posedge sys_clk)
        disable iff (!rstn) (hw_channel_start_ack[HW_START_CHAN]
        && start_level[HW_START_CHAN])
        |=> hw_channel_start_ack[HW_START_CHAN])
        else $error("ack dropped while start still high");

    // ack falls once the start level is withdrawn
    a_ack_released: assert property (@(posedge sys_clk)
        disable iff (!rstn) (!start_level[HW_START_CHAN]
        && !(hw_owned_q[HW_START_CHAN]
        && channel_finished[HW_START_CHAN]))
        |=> !hw_channel_start_ack[HW_START_CHAN])
        else $error("ack stayed after start was withdrawn");

    // reset clears internal state as well as outputs
    a_reset_state: assert property (@(posedge sys_clk)
        !rstn |=> state_q == IDLE && !xfer_is_last
        && hw_owned_q == '0 && start_level == '0)
        else $error("reset did not clear internal state");
endmodule // dma_flow_control_handshake

// ===== tb/slave_model.sv
`timescale 1ns/1ps
module slave_model (
    input  wire logic sys_clk,                    // DMA clock
    input  wire logic want,                       // Item wanted
    input  wire logic last,                       // Item is final
    input  wire logic xfer_done_strobe,           // Done pulse
    output logic      single_xfer_request = 1'b0, // Single request
    output logic      final_xfer_request  = 1'b0  // Final request
);
    // request levels
    // Drop on the done pulse so one request makes exactly one item
    always @(negedge sys_clk) begin
        if (xfer_done_strobe) begin
            single_xfer_request <= 1'b0;
            final_xfer_request  <= 1'b0;
        end else if (want) begin
            single_xfer_request <= ~last;
            final_xfer_request  <= last;
        end
    end
endmodule // slave_model

// ===== tb/tb_dma_flow_control_handshake.sv
`timescale 1ns/1ps
module tb_dma_flow_control_handshake;
    logic        sys_clk          = 1'b0;
    logic        rstn             = 1'b0;
    logic        want             = 1'b0;
    logic        last             = 1'b0;
    logic        xfer_complete    = 1'b0;
    logic [11:0] hw_channel_start = 12'h000;
    logic [11:0] channel_finished = 12'h000;
    wire         single_xfer_request, final_xfer_request, xfer_request;
    wire         xfer_is_last, terminal_count_out, xfer_done_strobe;
    wire  [11:0] channel_start, hw_channel_start_ack;
    logic [11:0] ack_meta_q       = 12'h000;
    logic [11:0] ack_sync_q       = 12'h000;
    int          errors           = 0;
    int          samples_checked  = 0;
    int          n;
    // Clock, and a mover that finishes one cycle after each request
    always #5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) xfer_complete <= xfer_request & ~xfer_complete;
    // far-side receiver does its own two-flop crossing of the ack
    always @(posedge sys_clk) begin
        ack_meta_q <= hw_channel_start_ack;
        ack_sync_q <= ack_meta_q;
    end
    dma_flow_control_handshake u_dma_flow_control_handshake (
        .sys_clk              (sys_clk),
        .rstn                 (rstn),
        .single_xfer_request  (single_xfer_request),
        .final_xfer_request   (final_xfer_request),
        .xfer_complete        (xfer_complete),
        .xfer_request         (xfer_request),
        .xfer_is_last         (xfer_is_last),
        .terminal_count_out   (terminal_count_out),
        .xfer_done_strobe     (xfer_done_strobe),
        .hw_channel_start     (hw_channel_start),
        .channel_finished     (channel_finished),
        .channel_start        (channel_start),
        .hw_channel_start_ack (hw_channel_start_ack)
    );
    slave_model u_slave_model (
        .sys_clk             (sys_clk),
        .want                (want),
        .last                (last),
        .xfer_done_strobe    (xfer_done_strobe),
        .single_xfer_request (single_xfer_request),
        .final_xfer_request  (final_xfer_request)
    );
    // Compare and count
    task automatic check(logic [11:0] seen, logic [11:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Report and stop
    task automatic test_done();
        $display("checked=%0d errors=%0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // A wait that ran out of cycles is a failure
    task automatic give_up();
        if (n == 0) begin
            errors++;
            test_done();
        end
    endtask
    // One slave item; back to back calls keep the minimum spacing
    task automatic one_item(logic fin);
        last <= fin;
        want <= 1'b1;
        for (n = 20; n > 0 && xfer_done_strobe !== 1'b1; n--)
            @(negedge sys_clk);
        give_up();
        want <= 1'b0;
        check(12'(terminal_count_out), 12'(fin));
        check(12'(xfer_is_last), 12'(fin));
        check(12'(xfer_request), 12'h000);
        @(negedge sys_clk);
        check(12'(xfer_done_strobe), 12'h000);
    endtask
    // Start bits 3 and 4 together; only 4 may start, optional reset
    task automatic hw_start(logic rst_mid);
        hw_channel_start <= 12'h018;
        for (n = 20; n > 0 && channel_start === 12'h000; n--)
            @(negedge sys_clk);
        give_up();
        check(channel_start, 12'h010);
        // Finish only once ownership is taken; start wins a shared cycle
        @(negedge sys_clk);
        channel_finished <= 12'h010;
        @(negedge sys_clk);
        channel_finished <= 12'h000;
        @(negedge sys_clk);
        check(hw_channel_start_ack, 12'h010);
        @(negedge sys_clk);
        check(ack_sync_q, 12'h010);
        if (rst_mid) rstn <= 1'b0;
        hw_channel_start <= 12'h000;
        repeat (6) @(negedge sys_clk);
        rstn <= 1'b1;
        check(hw_channel_start_ack, 12'h000);
    endtask
    // Main sequence
    initial begin
        repeat (6) @(negedge sys_clk);
        check(channel_start | hw_channel_start_ack, 12'h000);
        rstn <= 1'b1;
        one_item(1'b0);
        one_item(1'b1);
        one_item(1'b0);
        hw_start(1'b0);
        hw_start(1'b1);
        one_item(1'b1);
        test_done();
    end
endmodule // tb_dma_flow_control_handshake
